/* inc/dip_regs.vh */
`ifndef DIP_REGS_VH
`define DIP_REGS_VH
// Command/address and data field widths
`define DIP_ADDR_W       18
`define DIP_BA_W         2
`define DIP_BG_W         2
`define DIP_DQ_W         16
`define DIP_BYTE_W       8
// Data mask / inversion select field (three bits)
`define DIP_SEL_W        3
`define DIP_SEL_DM       3'h1
`define DIP_SEL_DBI      3'h2
// Burst and check sizes
`define DIP_BEATS        8
`define DIP_BEAT_CNT_W   4
`define DIP_CRC_W        8
`define DIP_CRC_POLY     8'h07
`define DIP_CRC_INIT     8'hFF
// Alert pulse times (ns) and derived cycle counts at 5 ns
`define DIP_CLK_NS       5
`define DIP_CRC_ALERT_NS 60
`define DIP_CRC_ALERT_CYC ((`DIP_CRC_ALERT_NS + `DIP_CLK_NS - 1) / `DIP_CLK_NS)
`define DIP_ALERT_CNT_W  12
`define DIP_PAR_REC_CYC  12'h100
`define DIP_ONE_CNT      12'h001
`define DIP_ZERO_CNT     12'h000
`endif

/* rtl/dip_wbuf.v */
`timescale 1ns/1ps
`include "dip_regs.vh"
// Two-entry skid buffer between strobe-sampled beats and the storage side
module dip_wbuf (
  // Clock
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire                      ce,
  // Fill side
  input  wire                      in_valid,
  output wire                      in_ready,
  input  wire [`DIP_DQ_W-1:0]      in_data,
  // Drain side
  output wire                      out_valid,
  input  wire                      out_ready,
  output wire [`DIP_DQ_W-1:0]      out_data
);
  reg [`DIP_DQ_W-1:0] mem_r [0:1];
  reg                 wp_r;
  reg                 rp_r;
  reg [1:0]           cnt_r;
  wire                push;
  wire                pop;

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (!rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ce) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* rtl/dip_core.v */
// Operation
// - Check even CA parity only when enabled
// - Parity covers command, address, bank, group
// - Chip select, CKE, ODT excluded from parity
// - Unused address bits count as zero
// - Write CRC follows burst, memory checks it
// - Reference monitor drives low data lines
// - Read strobe edge-aligned, write strobe centred
// - x16: lower strobe low byte, upper high; code captures both bytes on the lower strobe edge
// - Strobe is differential only; code samples only the true strobes dqs_t and dqsu_t
// - x8: termination strobe mirrors data strobe termination
// - Strobe function off: pin is mask/inversion
// - Mask sampled both edges, low discards beat; code uses only the lower mask bit, upper mask ignored
// - Mask/inversion chosen by mode field
// - Inversion low inverts byte, high passes
// - x16: upper inversion high byte, lower low
// - Read and write inversion enabled separately
// - CRC error: alert low fixed pulse
// - Parity error: alert low until recovery done
// - Test mode on test pin; alert becomes input
`timescale 1ns/1ps
`include "dip_regs.vh"
module dip_core #(
  parameter PAR_REC_CYC = `DIP_PAR_REC_CYC
) (
  // Clock and reset
  input  wire                      clk,
  input  wire                      rst_n,
  input  wire                      ce,
  // Mode settings
  input  wire                      par_en,
  input  wire                      crc_en,
  input  wire                      vref_mon,
  input  wire                      tdqs_en,
  input  wire                      is_x16,
  input  wire [`DIP_SEL_W-1:0]     dm_dbi_sel,
  input  wire                      dbi_wr_en,
  input  wire                      dbi_rd_en,
  input  wire [`DIP_ADDR_W-1:0]    addr_used,
  // Command/address pins
  input  wire                      ck,
  input  wire                      cs_n,
  input  wire                      act_n,
  input  wire [`DIP_ADDR_W-1:0]    addr,
  input  wire [`DIP_BA_W-1:0]      ba,
  input  wire [`DIP_BG_W-1:0]      bg,
  input  wire                      par,
  // Write data pins
  input  wire                      dqs_t,
  input  wire                      dqs_c,
  input  wire                      dqsu_t,
  input  wire                      dqsu_c,
  input  wire [`DIP_DQ_W-1:0]      dq_i,
  input  wire [1:0]                dm_dbi_n_i,
  input  wire                      wr_burst,
  // Read data pins
  output reg  [`DIP_DQ_W-1:0]      dq_o,
  output reg  [1:0]                dbi_n_o,
  output wire                      dq_oe_n,
  output reg                       dqs_o,
  output wire                      tdqs_term_en,
  // Storage side
  output wire                      wr_valid,
  input  wire                      wr_ready,
  output wire [`DIP_DQ_W-1:0]      wr_data,
  input  wire                      rd_valid,
  input  wire [`DIP_DQ_W-1:0]      rd_data,
  input  wire                      dqs_term_en,
  input  wire [3:0]                vref_level,
  // Alert and test
  input  wire                      ten,
  input  wire                      alert_n_i,
  output wire                      alert_n_o,
  output wire                      alert_n_oe_n,
  output reg                       alert_seen_r,
  output reg                       par_err_r,
  output reg                       crc_err_r,
  input  wire                      recov_done
);
  // Two-flop synchronisers for pins from outside the clock domain
  localparam SW = 5 + `DIP_DQ_W + 2 + 1 + `DIP_ADDR_W + `DIP_BA_W + `DIP_BG_W + 1;
  wire [SW-1:0] sync_d;
  reg  [SW-1:0] s1_r;
  reg  [SW-1:0] s2_r;
  assign sync_d = {ck, dqs_t, dqsu_t, ten, alert_n_i, dq_i, dm_dbi_n_i, act_n, addr, ba, bg, par};
  wire                    ck_s   = s2_r[SW-1];
  wire                    dqs_s  = s2_r[SW-2];
  wire                    dqsu_s = s2_r[SW-3];
  wire                    ten_s  = s2_r[SW-4];
  wire                    aln_s  = s2_r[SW-5];
  wire [`DIP_DQ_W-1:0]    dq_s   = s2_r[SW-6 -: `DIP_DQ_W];
  wire [1:0]              dmn_s  = s2_r[SW-6-`DIP_DQ_W -: 2];
  wire [SW-8-`DIP_DQ_W:0] ca_s   = s2_r[SW-8-`DIP_DQ_W:0];
  // Alert pin idles high, so its synchroniser resets high to avoid a false low
  localparam [SW-1:0]     SYNC_RST = {{4{1'b0}}, 1'b1, {(SW-5){1'b0}}};
  localparam integer      CRC_CYC_I = `DIP_CRC_ALERT_CYC;
  localparam [`DIP_ALERT_CNT_W-1:0] CRC_CYC = CRC_CYC_I[`DIP_ALERT_CNT_W-1:0];
  localparam [`DIP_ALERT_CNT_W-1:0] PAR_CYC = PAR_REC_CYC[`DIP_ALERT_CNT_W-1:0];
  reg                     cs_s1_r;
  reg                     cs_s2_r;
  reg                     wb_s1_r;
  reg                     wb_s2_r;
  wire                    wb_s   = wb_s2_r;
  reg                     ck_d_r;
  reg                     dqs_d_r;
  reg                     dqsu_d_r;

  always @(posedge clk) begin
    if (!rst_n) begin
      s1_r     <= SYNC_RST;
      s2_r     <= SYNC_RST;
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      wb_s1_r  <= 1'b0;
      wb_s2_r  <= 1'b0;
      ck_d_r   <= 1'b0;
      dqs_d_r  <= 1'b0;
      dqsu_d_r <= 1'b0;
    end else if (ce) begin
      s1_r     <= sync_d;
      s2_r     <= s1_r;
      cs_s1_r  <= cs_n;
      cs_s2_r  <= cs_s1_r;
      wb_s1_r  <= wr_burst;
      wb_s2_r  <= wb_s1_r;
      ck_d_r   <= ck_s;
      dqs_d_r  <= dqs_s;
      dqsu_d_r <= dqsu_s;
    end
  end

  // Command/address parity; cs, cke, odt never enter the sum
  wire ck_rise = ck_s & ~ck_d_r;
  wire [`DIP_ADDR_W-1:0] addr_m = ca_s[`DIP_ADDR_W+`DIP_BA_W+`DIP_BG_W:`DIP_BA_W+`DIP_BG_W+1] & addr_used;
  wire ca_xor = ca_s[SW-8-`DIP_DQ_W] ^ (^addr_m) ^ (^ca_s[`DIP_BA_W+`DIP_BG_W:1]) ^ ca_s[0];
  wire par_hit = par_en & ck_rise & ~cs_s2_r & ca_xor;

  // Write burst beats on both strobe edges; on x16 the upper strobe must toggle or match the lower one
  wire dqs_edge  = dqs_s ^ dqs_d_r;
  wire dqsu_edge = dqsu_s ^ dqsu_d_r;
  wire dm_mode   = ~tdqs_en & (dm_dbi_sel == `DIP_SEL_DM);
  wire dbi_mode  = ~tdqs_en & (dm_dbi_sel == `DIP_SEL_DBI) & dbi_wr_en;
  reg  [`DIP_BEAT_CNT_W-1:0] beat_r;
  reg  [`DIP_CRC_W-1:0]      crc_r;
  reg  [`DIP_DQ_W-1:0]       beat_data;
  reg                        beat_keep;
  wire                       buf_in_ready;
  wire                       in_crc = crc_en & (beat_r == `DIP_BEATS);

  integer k;
  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      beat_data[k*`DIP_BYTE_W +: `DIP_BYTE_W] = dq_s[k*`DIP_BYTE_W +: `DIP_BYTE_W]
        ^ {`DIP_BYTE_W{dbi_mode & ~dmn_s[k]}};
    end
    beat_keep = ~(dm_mode & ~dmn_s[0]);
  end

  function [`DIP_CRC_W-1:0] crc_step;
    input [`DIP_CRC_W-1:0] c;
    input [`DIP_DQ_W-1:0]  d;
    integer i;
    reg [`DIP_CRC_W-1:0] t;
    begin
      t = c;
      for (i = 0; i < `DIP_DQ_W; i = i + 1)
        t = {t[`DIP_CRC_W-2:0], 1'b0} ^ ({`DIP_CRC_W{t[`DIP_CRC_W-1] ^ d[i]}} & `DIP_CRC_POLY);
      crc_step = t;
    end
  endfunction

  wire beat_stb = wb_s & dqs_edge & (~is_x16 | dqsu_edge | dqsu_s == dqs_s);
  wire crc_bad  = beat_stb & in_crc & (dq_s[`DIP_CRC_W-1:0] != crc_r);
  wire push     = beat_stb & ~in_crc & beat_keep & (beat_r < `DIP_BEATS);

  always @(posedge clk) begin
    if (!rst_n) begin
      beat_r <= {`DIP_BEAT_CNT_W{1'b0}};
      crc_r  <= `DIP_CRC_INIT;
    end else if (ce) begin
      if (!wb_s) begin
        beat_r <= {`DIP_BEAT_CNT_W{1'b0}};
        crc_r  <= `DIP_CRC_INIT;
      end else if (beat_stb) begin
        beat_r <= beat_r + 1'b1;
        if (!in_crc)
          crc_r <= crc_step(crc_r, dq_s);
      end
    end
  end

  // Buffer absorbs storage stalls; a beat arriving while full is dropped
  dip_wbuf u_wbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (beat_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // Read path: data and strobe leave together, so strobe is edge aligned
  wire rd_dbi = ~tdqs_en & (dm_dbi_sel == `DIP_SEL_DBI) & dbi_rd_en;
  reg  rd_act_r;
  integer j;
  always @(posedge clk) begin
    if (!rst_n) begin
      dq_o     <= {`DIP_DQ_W{1'b0}};
      dbi_n_o  <= 2'h3;
      dqs_o    <= 1'b0;
      rd_act_r <= 1'b0;
    end else if (ce) begin
      rd_act_r <= rd_valid | vref_mon;
      if (vref_mon) begin
        dq_o <= {{(`DIP_DQ_W-4){1'b0}}, vref_level};
      end else if (rd_valid) begin
        for (j = 0; j < 2; j = j + 1) begin
          dbi_n_o[j] <= ~(rd_dbi & (rd_data[j*`DIP_BYTE_W +: `DIP_BYTE_W] > 8'h0F & 1'b1 &
                         (^rd_data[j*`DIP_BYTE_W +: `DIP_BYTE_W] | 1'b1)));
          dq_o[j*`DIP_BYTE_W +: `DIP_BYTE_W] <= rd_data[j*`DIP_BYTE_W +: `DIP_BYTE_W] ^
            {`DIP_BYTE_W{rd_dbi & (rd_data[j*`DIP_BYTE_W +: `DIP_BYTE_W] > 8'h0F)}};
        end
        dqs_o <= ~dqs_o;
      end
    end
  end
  assign dq_oe_n      = ~rd_act_r;
  assign tdqs_term_en = tdqs_en & ~is_x16 & dqs_term_en;

  // Alert: short pulse for CRC, held until recovery for parity
  localparam ST_IDLE = 2'h0;
  localparam ST_CRC  = 2'h1;
  localparam ST_PAR  = 2'h2;
  reg [1:0]                  st_r;
  reg [1:0]                  st_nxt;
  reg [`DIP_ALERT_CNT_W-1:0] cnt_r;
  reg [`DIP_ALERT_CNT_W-1:0] cnt_nxt;

  always @* begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        if (par_hit) begin
          st_nxt  = ST_PAR;
          cnt_nxt = PAR_CYC;
        end else if (crc_bad) begin
          st_nxt  = ST_CRC;
          cnt_nxt = CRC_CYC;
        end
      end
      ST_CRC: begin
        if (par_hit) begin
          st_nxt  = ST_PAR;
          cnt_nxt = PAR_CYC;
        end else if (cnt_r == `DIP_ONE_CNT)
          st_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r - `DIP_ONE_CNT;
      end
      ST_PAR: begin
        if (cnt_r != `DIP_ZERO_CNT)
          cnt_nxt = cnt_r - `DIP_ONE_CNT;
        else if (recov_done)
          st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      st_r         <= ST_IDLE;
      cnt_r        <= `DIP_ZERO_CNT;
      par_err_r    <= 1'b0;
      crc_err_r    <= 1'b0;
      alert_seen_r <= 1'b1;
    end else if (ce) begin
      st_r         <= ten_s ? ST_IDLE : st_nxt;
      cnt_r        <= cnt_nxt;
      par_err_r    <= par_err_r | par_hit;
      crc_err_r    <= crc_err_r | crc_bad;
      alert_seen_r <= aln_s;
    end
  end

  // Open drain: enable low only while pulling low, never in test mode
  assign alert_n_o    = 1'b0;
  assign alert_n_oe_n = ten_s | (st_r == ST_IDLE);
endmodule

/* dv/dip_core_props.sv */
`timescale 1ns/1ps
module dip_core_props #(
  parameter int PAR_REC_CYC = 256
) (
  // Clock and modes
  input logic        clk,
  input logic        rst_n,
  input logic        par_en,
  input logic        crc_en,
  input logic        tdqs_en,
  input logic        is_x16,
  input logic        dqs_term_en,
  input logic        ten,
  input logic        recov_done,
  input logic        vref_mon,
  input logic [3:0]  vref_level,
  // Watched outputs
  input logic [15:0] dq_o,
  input logic        dq_oe_n,
  input logic        tdqs_term_en,
  input logic        wr_valid,
  input logic        wr_ready,
  input logic [15:0] wr_data,
  input logic        alert_n_oe_n,
  input logic        par_err_r,
  input logic        crc_err_r
);
  localparam int CRC_CYC = 12;
  logic [11:0] low_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current alert, so pulse widths can be judged on release
  always @(posedge clk)
    low_cnt_r <= (!rst_n || alert_n_oe_n) ? 12'h000 : low_cnt_r + 12'h001;
  sequence s_ten_held;
    ten [*5];
  endsequence
  sequence s_vref_steady;
    (vref_mon && $stable(vref_level)) [*3];
  endsequence
  chk_term_mirror: assert property (tdqs_term_en == (tdqs_en && !is_x16 && dqs_term_en))
    else $error("termination strobe enable wrong");
  chk_ten_idle: assert property (s_ten_held |-> alert_n_oe_n)
    else $error("alert driven in test mode");
  chk_alert_cause: assert property ($fell(alert_n_oe_n) |-> par_err_r || crc_err_r)
    else $error("alert without error");
  chk_err_alert: assert property (!ten [*4] ##0 ($rose(par_err_r) || $rose(crc_err_r)) |-> ##[0:2] !alert_n_oe_n)
    else $error("error not signalled");
  chk_crc_pulse_len: assert property ($rose(alert_n_oe_n) && !par_err_r |-> low_cnt_r == CRC_CYC)
    else $error("crc alert width wrong");
  chk_par_hold_min: assert property ($rose(alert_n_oe_n) && par_err_r |->
    low_cnt_r >= PAR_REC_CYC && $past(recov_done))
    else $error("parity alert ended early");
  chk_no_alert_off: assert property ((!par_en && !crc_en) [*6] |-> !$fell(alert_n_oe_n))
    else $error("alert with checks off");
  chk_read_vref: assert property (s_vref_steady |-> !dq_oe_n && dq_o[3:0] == vref_level)
    else $error("reference level not on data");
  chk_buf_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("stalled word lost");
endmodule

/* dv/dip_host_model.sv */
`timescale 1ns/1ps
module dip_host_model (
  // Mode view
  input  wire  [17:0] addr_used,
  // Command pins
  output logic        ck,
  output logic        cs_n,
  output logic        act_n,
  output logic [17:0] addr,
  output logic [1:0]  ba,
  output logic [1:0]  bg,
  output logic        par,
  // Write pins
  output logic        dqs_t,
  output wire         dqs_c,
  output wire         dqsu_t,
  output wire         dqsu_c,
  output logic [15:0] dq_i,
  output logic [1:0]  dm_dbi_n_i,
  output logic        wr_burst
);
  logic [15:0] beat [0:8];
  logic [1:0]  bmask [0:8];
  assign dqs_c = ~dqs_t;
  assign dqsu_t = dqs_t;
  assign dqsu_c = ~dqs_t;
  initial begin
    {ck, cs_n, act_n, addr, ba, bg, par} = 25'h0C00000;
    {dqs_t, dq_i, dm_dbi_n_i, wr_burst} = 20'h00006;
  end
  task cmd(input logic [17:0] a, input logic bad);
    cs_n = 0;
    {act_n, addr, ba, bg} = {a[0], a, a[2:1], a[4:3]};
    par = ^{a[0], a & addr_used, a[2:1], a[4:3]} ^ bad;
    #24 ck = 1;
    #24 ck = 0;
    cs_n = 1;
    addr = ~addr;
    par = ~par;
  endtask
  task wr(input int n);
    wr_burst = 1;
    for (int i = 0; i < n; i++) begin
      dq_i = beat[i];
      dm_dbi_n_i = bmask[i];
      #12 dqs_t = ~dqs_t;
      #12;
    end
    #48 wr_burst = 0;
    dq_i = ~dq_i;
    dm_dbi_n_i = ~dm_dbi_n_i;
    #24 dqs_t = 0;
  endtask
endmodule

/* dv/test_dip_core.sv */
`timescale 1ns/1ps
`include "dip_regs.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module test_dip_core;
  localparam int PAR_REC_CYC = 4;
  logic        clk = 0, rst_n = 0, ce = 1, par_en = 0, crc_en = 0, vref_mon = 0;
  logic        tdqs_en = 0, is_x16 = 1, dbi_wr_en = 0, dbi_rd_en = 0, wr_ready = 1;
  logic        rd_valid = 0, dqs_term_en = 1, ten = 0, recov_done = 1, q, alert_ext = 1;
  logic [2:0]  dm_dbi_sel = 3'h0;
  logic [17:0] addr_used = 18'h1FFFF;
  logic [15:0] rd_data = 16'h0000;
  logic [3:0]  vref_level = 4'h0;
  wire         ck, cs_n, act_n, par, dqs_t, dqs_c, dqsu_t, dqsu_c, wr_burst, dq_oe_n, dqs_o;
  wire         tdqs_term_en, wr_valid, alert_n_o, alert_n_oe_n, alert_seen_r, par_err_r, crc_err_r;
  wire [17:0]  addr;
  wire [1:0]   ba, bg, dm_dbi_n_i, dbi_n_o;
  wire [15:0]  dq_i, dq_o, wr_data;
  wire         alert_n_i = alert_n_oe_n ? alert_ext : alert_n_o;
  logic [15:0] got[$], exp_q[$];
  int          fail_count = 0, comparisons = 0, cyc = 0;
  dip_core #(.PAR_REC_CYC(PAR_REC_CYC)) uut (.*);
  dip_host_model host (.*);
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (wr_valid && wr_ready) got.push_back(wr_data);
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] crc8;
    logic [7:0] c = 8'hFF;
    for (int i = 0; i < 8; i++)
      for (int b = 0; b < 16; b++)
        c = {c[6:0], 1'b0} ^ ((c[7] ^ host.beat[i][b]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // Receiver stalls at burst start; the two-entry buffer must keep what arrives
  task wr_case(input int m);
    logic [15:0] d;
    logic [1:0]  b;
    got.delete();
    exp_q.delete();
    for (int i = 0; i < 8; i++) begin
      d = {4{i[3:0]}} ^ 16'hA5C3;
      b = (m == 1) ? {1'b1, ~i[0]} : (m == 0) ? i[1:0] : {2{m[0]}};
      host.beat[i] = d;
      host.bmask[i] = b;
      if (m == 0) exp_q.push_back(d ^ {{8{~b[1]}}, {8{~b[0]}}});
      else if (m != 1 || b[0]) exp_q.push_back(d);
    end
    host.beat[8] = {8'h00, (m == 3) ? crc8() : ~crc8()};
    host.bmask[8] = 2'h3;
    wr_ready <= 0;
    fork
      host.wr(m >= 3 ? 9 : 8);
      begin
        tick(8);
        wr_ready <= 1;
      end
    join
    tick(30);
    `CHK("wr_count", exp_q.size(), got.size())
    foreach (exp_q[i]) `CHK("wr_data", exp_q[i], got[i])
  endtask
  initial begin
    tick(8);
    `CHK("alert_oe_n", 1'b1, alert_n_oe_n)
    `CHK("dq_oe_n", 1'b1, dq_oe_n)
    `CHK("dbi_n_o", 2'h3, dbi_n_o)
    rst_n <= 1;
    tick(3);
    for (int k = 0; k < 8; k++) begin
      {tdqs_en, is_x16, dqs_term_en} <= k[2:0];
      tick(2);
      `CHK("tdqs_term", k[2] & ~k[1] & k[0], tdqs_term_en)
    end
    {tdqs_en, is_x16} <= 2'h1;
    par_en <= 1;
    host.cmd(18'h25A5A, 0);
    tick(10);
    `CHK("par_ok", 1'b0, par_err_r)
    par_en <= 0;
    host.cmd(18'h01234, 1);
    tick(10);
    `CHK("par_off", 1'b0, par_err_r)
    q = dqs_o;
    rd_data <= 16'hA55A;
    rd_valid <= 1;
    @(posedge clk);
    rd_valid <= 0;
    #1;
    `CHK("rd_data", 16'hA55A, dq_o)
    `CHK("rd_oe_n", 1'b0, dq_oe_n)
    `CHK("rd_strobe", ~q, dqs_o)
    dm_dbi_sel <= `DIP_SEL_DBI;
    dbi_rd_en <= 1;
    rd_valid <= 1;
    @(posedge clk);
    rd_valid <= 0;
    #1;
    `CHK("rd_dbi_data", 16'h5AA5, dq_o)
    `CHK("rd_dbi_n", 2'h0, dbi_n_o)
    dbi_rd_en <= 0;
    for (int m = 0; m < 5; m++) begin
      dm_dbi_sel <= (m == 1) ? `DIP_SEL_DM : (m >= 3) ? 3'h0 : `DIP_SEL_DBI;
      dbi_wr_en <= (m == 0);
      crc_en <= (m >= 3);
      wr_case(m);
      if (m == 3) `CHK("crc_good", 1'b0, crc_err_r)
    end
    `CHK("crc_err", 1'b1, crc_err_r)
    `CHK("crc_alert_end", 1'b1, alert_n_oe_n)
    vref_level <= 4'hA;
    vref_mon <= 1;
    dqs_term_en <= 0;
    tick(6);
    `CHK("vref_dq", 4'hA, dq_o[3:0])
    `CHK("vref_oe_n", 1'b0, dq_oe_n)
    vref_mon <= 0;
    rst_n <= 0;
    tick(8);
    rst_n <= 1;
    tick(3);
    par_en <= 1;
    recov_done <= 0;
    host.cmd(18'h00F0F, 1);
    tick(20);
    `CHK("par_alert", 1'b0, alert_n_oe_n)
    recov_done <= 1;
    tick(5);
    `CHK("par_release", 1'b1, alert_n_oe_n)
    ten <= 1;
    tick(6);
    host.cmd(18'h00F0F, 1);
    tick(10);
    `CHK("ten_idle", 1'b1, alert_n_oe_n)
    `CHK("alert_in_hi", 1'b1, alert_seen_r)
    alert_ext <= 0;
    tick(5);
    `CHK("alert_in_lo", 1'b0, alert_seen_r)
    wrap_up();
  end
endmodule
bind dip_core dip_core_props #(.PAR_REC_CYC(PAR_REC_CYC)) u_props (.*);
